// [hw/dram_primary_port_access_sequencer.sv]
/*
 * Primary-port access sequencer: row/column strobes, acknowledge, wait,
 * address latches with column advance, and address pipelining.
 * Assumes all host inputs are synchronous to clk_sys and that refresh
 * and secondary-port arbitration live outside and report busy levels.
 */
`timescale 1ns/1ps
module dram_primary_port_access_sequencer #(
    parameter int COL_HOLD_CYC = 1
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic prog_load, // Programming pulse
    input wire dram_seq_pkg::cfg_t cfg_in, // Programming selections
    input wire logic latch_strobe, // Sync-mode start strobe
    input wire logic chip_select_n, // Chip select
    input wire logic address_strobe_n, // Async-mode start strobe
    input wire logic access_hold_request_n, // Hold request
    input wire logic [dram_seq_pkg::CAS_N-1:0] column_extend_inputs_n, // Extend
    input wire logic write_request_n, // Write request
    input wire logic column_advance, // Column increment
    input wire dram_seq_pkg::dram_addr_t addr_in, // Row, column, bank
    input wire logic refresh_busy, // Refresh in progress
    input wire logic secondary_port_grant, // Other port granted
    input wire logic refresh_request_n, // Refresh request from arbiter
    output logic row_strobe_n, // Row strobe
    output logic [dram_seq_pkg::CAS_N-1:0] column_strobe_n, // Column strobes
    output logic transfer_acknowledge_n, // Acknowledge
    output logic wait_n, // Wait
    output logic [dram_seq_pkg::ADDR_W-1:0] dram_addr, // Multiplexed address
    output logic [dram_seq_pkg::BANK_W-1:0] dram_bank, // Bank select
    output logic write_strobe_n // Write strobe or refresh request
);
    import dram_seq_pkg::*;

    initial begin
        if (COL_HOLD_CYC < 1 || COL_HOLD_CYC > 7) begin
            $error("COL_HOLD_CYC must be 1..7");
        end
    end

    // ==========================================================
    // Programming capture
    cfg_t cfg_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_r <= CFG_RESET;
        end else if (prog_load) begin
            cfg_r <= cfg_in;
        end
    end

    // ==========================================================
    // Start detection
    seq_state_t state_r, state_nxt;
    logic ale_prev_r, ads_prev_r, ads_armed_r, pend_r, pend_nxt;
    logic start_ev, launch, ready, pre_ok, access_hold_request_n_seen_r, access_end;
    logic ads_fall;

    assign ads_fall = ~address_strobe_n & ads_prev_r;

    always_comb begin
        if (cfg_r.async_mode == MODE_ASYNC) begin
            start_ev = ~address_strobe_n & ads_armed_r & ~chip_select_n;
        end else begin
            start_ev = latch_strobe & ~ale_prev_r & ~chip_select_n;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ale_prev_r <= 1'b0;
            ads_prev_r <= 1'b1;
        end else begin
            ale_prev_r <= latch_strobe;
            ads_prev_r <= address_strobe_n;
        end
    end

    // Strobe must go high again before it can start another access
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ads_armed_r <= 1'b0;
        end else if (address_strobe_n) begin
            ads_armed_r <= 1'b1;
        end else if (start_ev) begin
            ads_armed_r <= 1'b0;
        end
    end

    // A start seen during an access waits here (pipelining)
    assign pend_nxt = (pend_r | start_ev) & ~launch;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // ==========================================================
    // Secondary grant and address latch timing
    logic [1:0] gnt_cnt_r;
    logic gnt_ok, gnt_pulse;

    assign gnt_ok = ~secondary_port_grant && gnt_cnt_r == 2'h0;
    assign gnt_pulse = ~secondary_port_grant && gnt_cnt_r == 2'h1;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gnt_cnt_r <= 2'h0;
        end else if (secondary_port_grant) begin
            gnt_cnt_r <= cfg_r.precharge[GNT_BIT] ? GNT_SECOND : GNT_FIRST;
        end else if (gnt_cnt_r != 2'h0) begin
            gnt_cnt_r <= gnt_cnt_r - 2'h1;
        end
    end

    dram_addr_t addr_r, addr_cur;
    logic load_addr;

    always_comb begin
        if (!cfg_r.latch_en) begin
            load_addr = 1'b1;
        end else if (cfg_r.async_mode == MODE_ASYNC) begin
            load_addr = ads_fall | (address_strobe_n && state_r == ST_IDLE && !pend_r);
        end else begin
            load_addr = latch_strobe;
        end
        load_addr = load_addr | gnt_pulse;
        addr_cur = load_addr ? addr_in : addr_r;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_r <= '0;
        end else if (load_addr) begin
            addr_r <= addr_in;
        end else if (column_advance) begin
            addr_r.col <= addr_r.col + 1'b1;
        end
    end

    // ==========================================================
    // Precharge tracking
    logic [1:0] pre_cnt_r, pre_time;
    logic [BANK_W-1:0] bank_last_r;
    logic pre_all_r, rf_prev_r;

    always_comb begin
        case (cfg_r.precharge)
            2'h0: pre_time = PRE_T00;
            2'h1: pre_time = PRE_T01;
            2'h2: pre_time = PRE_T10;
            default: pre_time = PRE_T11;
        endcase
    end

    // Refresh touches every bank, so its precharge blocks all of them
    assign pre_ok = pre_cnt_r == 2'h0 || (!pre_all_r && addr_cur.bank != bank_last_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_cnt_r <= 2'h0;
            pre_all_r <= 1'b0;
            rf_prev_r <= 1'b0;
            bank_last_r <= '0;
        end else begin
            rf_prev_r <= refresh_busy;
            if (launch) begin
                bank_last_r <= addr_cur.bank;
            end
            if (rf_prev_r && !refresh_busy) begin
                pre_cnt_r <= pre_time;
                pre_all_r <= 1'b1;
            end else if (access_end) begin
                pre_cnt_r <= pre_time;
                pre_all_r <= 1'b0;
            end else if (pre_cnt_r != 2'h0) begin
                pre_cnt_r <= pre_cnt_r - 2'h1;
            end
        end
    end

    // ==========================================================
    // Access sequencer
    logic [2:0] hold_cnt_r;
    logic hold_done;

    assign ready = ~refresh_busy & ~rf_prev_r & gnt_ok & pre_ok;
    assign launch = (start_ev | pend_r) && state_r == ST_IDLE && ready;
    assign access_end = state_r == ST_COL && access_hold_request_n_seen_r && access_hold_request_n;
    assign hold_done = hold_cnt_r >= 3'(COL_HOLD_CYC);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (launch) begin
                    state_nxt = ST_ROW;
                end
            end
            ST_ROW: state_nxt = ST_COL;
            ST_COL: begin
                if (access_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Hold request is honoured only once the host has actually raised it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            access_hold_request_n_seen_r <= 1'b0;
        end else if (state_nxt == ST_IDLE) begin
            access_hold_request_n_seen_r <= 1'b0;
        end else if (!access_hold_request_n) begin
            access_hold_request_n_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_cnt_r <= 3'h0;
        end else if (state_nxt != ST_COL) begin
            hold_cnt_r <= 3'h0;
        end else if (!hold_done) begin
            hold_cnt_r <= hold_cnt_r + 3'h1;
        end
    end

    // ==========================================================
    // Strobe outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            row_strobe_n <= 1'b1;
            transfer_acknowledge_n <= 1'b1;
            wait_n <= 1'b1;
        end else begin
            row_strobe_n <= state_nxt == ST_IDLE;
            transfer_acknowledge_n <= !(cfg_r.ack_en && state_nxt == ST_COL);
            wait_n <= !(cfg_r.wait_en && pend_nxt);
        end
    end

    // Extended strobes release lane by lane and never re-assert late
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            column_strobe_n <= '1;
        end else if (state_nxt == ST_COL) begin
            column_strobe_n <= cfg_r.cas_extend ? column_extend_inputs_n : '0;
        end else if (cfg_r.cas_extend) begin
            column_strobe_n <= column_strobe_n | column_extend_inputs_n;
        end else begin
            column_strobe_n <= '1;
        end
    end

    // ==========================================================
    // Address and write outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dram_addr <= '0;
            dram_bank <= '0;
        end else begin
            dram_bank <= addr_cur.bank;
            if (state_nxt == ST_COL && !(cfg_r.pipeline && state_r == ST_COL && hold_done)) begin
                dram_addr <= addr_cur.col;
            end else begin
                dram_addr <= addr_cur.row;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_strobe_n <= 1'b1;
        end else begin
            write_strobe_n <= cfg_r.pipeline ? refresh_request_n : write_request_n;
        end
    end

    // ==========================================================
    // Assertions
    a_start_row: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_IDLE && start_ev && ready) |=> !row_strobe_n)
        else $error("row strobe missed a ready start");
    a_busy_delay: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_IDLE && (refresh_busy || secondary_port_grant)) |=> row_strobe_n)
        else $error("row strobe asserted while busy");
    a_end_release: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_COL && access_hold_request_n_seen_r && access_hold_request_n)
        |=> row_strobe_n && transfer_acknowledge_n)
        else $error("access did not end on hold release");
    a_ack_span: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_r.ack_en && $rose(row_strobe_n == 1'b0)) |=> !transfer_acknowledge_n)
        else $error("acknowledge not one cycle after row strobe");
    a_rearm_ads: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_r.async_mode && state_r == ST_IDLE && !ads_armed_r && !pend_r)
        |=> row_strobe_n)
        else $error("access started without strobe rearm");
    a_cas_follow: assert property (@(posedge clk_sys) disable iff (rst)
        (!cfg_r.cas_extend && $rose(row_strobe_n)) |-> &column_strobe_n)
        else $error("column strobe outlived row strobe");
    a_cas_extend: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_r.cas_extend && state_r == ST_IDLE && !launch && !prog_load)
        |=> column_strobe_n == ($past(column_strobe_n) | $past(column_extend_inputs_n)))
        else $error("extended column strobe misbehaved");
    a_col_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        (!load_addr && column_advance)
        |=> addr_r.col == ADDR_W'($past(addr_r.col) + 1'b1))
        else $error("column advance did not increment");
    a_latch_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_r.latch_en && !cfg_r.async_mode && !latch_strobe && !column_advance
         && !gnt_pulse && !prog_load) |=> $stable(addr_r))
        else $error("closed latch changed");
    a_pre_refresh: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_IDLE && pre_all_r && pre_cnt_r != 2'h0) |=> row_strobe_n)
        else $error("precharge after refresh violated");
    a_wstrobe_mux: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_r.pipeline && !prog_load) |=> write_strobe_n == $past(refresh_request_n))
        else $error("write strobe not refresh request");
    a_cfg_stable: assert property (@(posedge clk_sys) disable iff (rst)
        !prog_load |=> $stable(cfg_r))
        else $error("programming changed without load");
    a_wait_start: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_r.wait_en && start_ev && !launch) |=> !wait_n)
        else $error("wait not asserted on start");

    c_sync_access: cover property (@(posedge clk_sys) disable iff (rst)
        !cfg_r.async_mode && launch ##[1:20] access_end);
    c_async_access: cover property (@(posedge clk_sys) disable iff (rst)
        cfg_r.async_mode && launch ##[1:20] access_end);
    c_pipelined: cover property (@(posedge clk_sys) disable iff (rst)
        cfg_r.pipeline && state_r == ST_COL && pend_r);
    c_cas_extend: cover property (@(posedge clk_sys) disable iff (rst)
        cfg_r.cas_extend && row_strobe_n && !(&column_strobe_n));
endmodule // dram_primary_port_access_sequencer

// [pkg/dram_seq_pkg.sv]
/*
 * Shared constants, types and state codes for the primary-port DRAM
 * access sequencer. Assumes one system clock for host, device and DRAM.
 */
package dram_seq_pkg;
    // ==========================================================
    // Address shape
    localparam int ADDR_W = 9;
    localparam int BANK_W = 2;
    localparam int CAS_N = 4;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
    } dram_addr_t;

    // ==========================================================
    // Programming-time selections
    typedef struct packed {
        logic async_mode;   // 0 sync (latch strobe), 1 async (addr strobe)
        logic latch_en;     // 1 latch address, 0 transparent
        logic cas_extend;   // 1 column strobes follow extend inputs
        logic pipeline;     // Address pipelining
        logic [1:0] precharge; // Precharge timing bits
        logic ack_en;       // Acknowledge output enabled
        logic wait_en;      // Wait output enabled
    } cfg_t;

    localparam cfg_t CFG_RESET = '0;
    localparam logic MODE_SYNC = 1'b0;
    localparam logic MODE_ASYNC = 1'b1;

    // ==========================================================
    // Timing, in clock edges
    localparam logic [1:0] PRE_T00 = 2'h1;
    localparam logic [1:0] PRE_T01 = 2'h2;
    localparam logic [1:0] PRE_T10 = 2'h2;
    localparam logic [1:0] PRE_T11 = 2'h3;
    localparam int GNT_BIT = 0;     // Precharge bit choosing 1st/2nd edge
    localparam logic [1:0] GNT_FIRST = 2'h1;
    localparam logic [1:0] GNT_SECOND = 2'h2;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ROW = 3'b010,
        ST_COL = 3'b100
    } seq_state_t;
endpackage

// [testbench/host_master_model.sv]
/*
 * Host bus master model: start strobes, chip select, hold request, address.
 * Assumes it shares clk_sys with the sequencer; every change lands 1 ns
 * after a rising edge.
 */
`timescale 1ns/1ps
module host_master_model (
    input wire logic clk_sys, // System clock
    output logic latch_strobe, // Sync start
    output logic chip_select_n, // Chip select
    output logic address_strobe_n, // Async start
    output logic access_hold_request_n, // Hold request
    output dram_seq_pkg::dram_addr_t addr_in // Address
);
    import dram_seq_pkg::*;
    initial begin
        latch_strobe = 1'b0;
        chip_select_n = 1'b1;
        address_strobe_n = 1'b1;
        access_hold_request_n = 1'b1;
        addr_in = '0;
    end
    // ==========================================================
    // Primitives, all synchronous to the clock
    task go_sync(input dram_addr_t a);
        @(posedge clk_sys);
        #1 latch_strobe = 1'b1;
        chip_select_n = 1'b0;
        addr_in = a;
    endtask
    task go_async(input dram_addr_t a);
        @(posedge clk_sys);
        #1 chip_select_n = 1'b0;
        address_strobe_n = 1'b1;
        addr_in = a;
        @(posedge clk_sys);
        #1 address_strobe_n = 1'b0; // Hold comes with the strobe
        access_hold_request_n = 1'b0;
    endtask
    // Released bus shows the inverse, or the old address when keep_addr is set
    task hold_on(input bit keep_ads, input bit keep_addr);
        @(posedge clk_sys);
        #1 access_hold_request_n = 1'b0;
        latch_strobe = 1'b0;
        chip_select_n = 1'b1;
        if (!keep_ads) address_strobe_n = 1'b1;
        if (!keep_addr) addr_in = ~addr_in;
    endtask
    task hold_off();
        @(posedge clk_sys);
        #1 access_hold_request_n = 1'b1;
    endtask
    task select_only();
        @(posedge clk_sys);
        #1 chip_select_n = 1'b0;
    endtask
endmodule // host_master_model

// [testbench/test_dram_primary_port_access_sequencer.sv]
/*
 * Self-checking bench for the primary-port access sequencer.
 * Assumes host_master_model drives the host strobes; checks land 2 ns
 * after the edge whose outputs they judge.
 */
`timescale 1ns/1ps
module test_dram_primary_port_access_sequencer;
    import dram_seq_pkg::*;
    logic clk_sys, rst, prog_load, latch_strobe, chip_select_n, address_strobe_n;
    logic access_hold_request_n, write_request_n, column_advance, refresh_busy;
    logic secondary_port_grant, refresh_request_n, row_strobe_n, transfer_acknowledge_n;
    logic wait_n, write_strobe_n;
    logic [CAS_N-1:0] column_extend_inputs_n, column_strobe_n;
    logic [ADDR_W-1:0] dram_addr;
    logic [BANK_W-1:0] dram_bank;
    cfg_t cfg_in;
    dram_addr_t addr_in;
    int num_errors = 0;
    int num_checks = 0;
    localparam dram_addr_t A = '{bank: 2'h0, row: 9'h0a5, col: 9'h1ff};
    localparam dram_addr_t B = '{bank: 2'h1, row: 9'h15a, col: 9'h033};

    dram_primary_port_access_sequencer #(.COL_HOLD_CYC(1)) DUT (.clk_sys(clk_sys),
        .rst(rst), .prog_load(prog_load), .cfg_in(cfg_in), .latch_strobe(latch_strobe),
        .chip_select_n(chip_select_n), .address_strobe_n(address_strobe_n),
        .access_hold_request_n(access_hold_request_n),
        .column_extend_inputs_n(column_extend_inputs_n), .write_request_n(write_request_n),
        .column_advance(column_advance), .addr_in(addr_in), .refresh_busy(refresh_busy),
        .secondary_port_grant(secondary_port_grant), .refresh_request_n(refresh_request_n),
        .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .transfer_acknowledge_n(transfer_acknowledge_n), .wait_n(wait_n),
        .dram_addr(dram_addr), .dram_bank(dram_bank), .write_strobe_n(write_strobe_n));
    host_master_model host (.clk_sys(clk_sys), .latch_strobe(latch_strobe),
        .chip_select_n(chip_select_n), .address_strobe_n(address_strobe_n),
        .access_hold_request_n(access_hold_request_n), .addr_in(addr_in));

    // ==========================================================
    // Helpers
    task chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function cfg_t mk(input bit am, input bit le, input bit ce, input bit pl,
                      input bit [1:0] pr);
        return '{am, le, ce, pl, pr, 1'b1, 1'b1};
    endfunction
    // Cfg_in is scrambled after the load pulse; selections must not move
    task prog(input cfg_t c);
        @(posedge clk_sys);
        #1 cfg_in = c;
        prog_load = 1'b1;
        @(posedge clk_sys);
        #1 prog_load = 1'b0;
        cfg_in = ~c;
    endtask
    task run_acc(input bit am, input dram_addr_t a, input logic [8:0] ecol, input bit keep);
        if (am) host.go_async(a);
        else host.go_sync(a);
        host.hold_on(keep, 1'b0);
        #1 chk(row_strobe_n === 1'b0 && dram_addr === a.row, "row phase");
        chk(dram_bank === a.bank, "bank");
        @(posedge clk_sys);
        #2 chk(transfer_acknowledge_n === 1'b0 && dram_addr === ecol, "col phase");
    endtask
    task end_acc();
        host.hold_off();
        @(posedge clk_sys);
        #2 chk(row_strobe_n === 1'b1 && transfer_acknowledge_n === 1'b1, "end");
    endtask
    task wait_row(input int lim, output int n);
        n = 0;
        while (row_strobe_n !== 1'b0 && n < lim) begin
            @(posedge clk_sys);
            #2 n++;
        end
    endtask

    // ==========================================================
    // Scenarios
    task t_sync_basic();
        prog(mk(MODE_SYNC, 1'b1, 1'b0, 1'b0, 2'h0));
        write_request_n = 1'b0;
        run_acc(1'b0, A, A.col, 1'b0);
        chk(column_strobe_n === 4'h0 && write_strobe_n === 1'b0, "cas, write");
        end_acc();
        chk(column_strobe_n === 4'hf, "cas ends with hold");
        write_request_n = 1'b1;
    endtask
    task t_async_rearm();
        int n;
        prog(mk(MODE_ASYNC, 1'b1, 1'b0, 1'b0, 2'h0));
        run_acc(1'b1, B, B.col, 1'b0);
        end_acc();
        run_acc(1'b1, A, A.col, 1'b1);
        end_acc();
        host.select_only();
        wait_row(4, n);
        chk(n == 4, "no restart while strobe stays low");
        run_acc(1'b1, B, B.col, 1'b0);
        end_acc();
    endtask
    task t_busy();
        int n;
        prog(mk(MODE_SYNC, 1'b1, 1'b0, 1'b0, 2'h0));
        for (int i = 0; i < 2; i++) begin
            {refresh_busy, secondary_port_grant} = i ? 2'b01 : 2'b10;
            host.go_sync(A);
            host.hold_on(1'b0, i == 1);
            repeat (3) @(posedge clk_sys);
            #2 chk(row_strobe_n === 1'b1 && wait_n === 1'b0, "held off, wait");
            {refresh_busy, secondary_port_grant} = 2'b00;
            wait_row(6, n);
            chk(n < 6 && dram_addr === A.row, "launch after busy");
            @(posedge clk_sys);
            end_acc();
        end
    endtask
    task t_precharge();
        int n;
        prog(mk(MODE_SYNC, 1'b1, 1'b0, 1'b0, 2'h3));
        run_acc(1'b0, A, A.col, 1'b0);
        end_acc();
        run_acc(1'b0, B, B.col, 1'b0); // Other bank needs no gap
        end_acc();
        host.go_sync(B);
        host.hold_on(1'b0, 1'b0);
        #1 chk(row_strobe_n === 1'b1, "same bank waits");
        wait_row(6, n);
        chk(n < 6, "same bank launches");
        @(posedge clk_sys);
        end_acc();
    endtask
    task t_extend();
        prog(mk(MODE_SYNC, 1'b1, 1'b1, 1'b0, 2'h0));
        column_extend_inputs_n = 4'h0;
        run_acc(1'b0, A, A.col, 1'b0);
        @(posedge clk_sys);
        #1 column_extend_inputs_n = 4'hf;
        @(posedge clk_sys);
        #1 write_request_n = 1'b0;
        @(posedge clk_sys);
        #2 chk(column_strobe_n === 4'hf && write_strobe_n === 1'b0, "rmw write");
        @(posedge clk_sys);
        #1 column_extend_inputs_n = 4'h0;
        end_acc();
        chk(column_strobe_n === 4'h0, "cas kept by extend");
        write_request_n = 1'b1;
        @(posedge clk_sys);
        #1 column_extend_inputs_n = 4'h5;
        @(posedge clk_sys);
        #2 chk(column_strobe_n === 4'h5, "lanes released");
        column_extend_inputs_n = 4'hf;
    endtask
    task t_column_advance();
        int n;
        prog(mk(MODE_SYNC, 1'b1, 1'b0, 1'b0, 2'h0));
        run_acc(1'b0, A, A.col, 1'b0);
        column_advance = 1'b1;
        @(posedge clk_sys);
        #1 column_advance = 1'b0;
        n = 0;
        while (dram_addr !== 9'h000 && n < 3) begin
            @(posedge clk_sys);
            #2 n++;
        end
        chk(n < 3, "column wraps to zero");
        end_acc();
    endtask
    task t_transparent();
        prog(mk(MODE_SYNC, 1'b0, 1'b0, 1'b0, 2'h0));
        run_acc(1'b0, B, ~B.col, 1'b0);
        end_acc();
    endtask
    task t_pipeline();
        prog(mk(MODE_SYNC, 1'b1, 1'b0, 1'b1, 2'h0));
        refresh_request_n = 1'b0;
        run_acc(1'b0, B, B.col, 1'b0);
        @(posedge clk_sys);
        #2 chk(dram_addr === B.row, "next row after hold");
        chk(write_strobe_n === 1'b0, "refresh request out");
        refresh_request_n = 1'b1;
        end_acc();
    endtask

    // ==========================================================
    // Clock, reset, sequence
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000 num_errors++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        prog_load = 1'b0;
        cfg_in = CFG_RESET;
        write_request_n = 1'b1;
        column_advance = 1'b0;
        refresh_busy = 1'b0;
        secondary_port_grant = 1'b0;
        refresh_request_n = 1'b1;
        column_extend_inputs_n = 4'hf;
        repeat (6) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_sync_basic();
        t_async_rearm();
        t_busy();
        t_precharge();
        t_extend();
        t_column_advance();
        t_transparent();
        t_pipeline();
        print_verdict();
    end
endmodule // test_dram_primary_port_access_sequencer
